// File: core/ros_pkg.sv
package ros_pkg;

  // ----------------------------------------------------------------
  // slot and code geometry
  // ----------------------------------------------------------------
  localparam int SLOT_COUNT = 16;
  localparam int CODE_W = 7;
  localparam int SRC_W = 128;
  localparam int GP_COUNT = 16;
  localparam int DSEL_COUNT = 6;
  localparam int CMD_COUNT = 18;
  localparam int PIN_COUNT = 10;

  // ----------------------------------------------------------------
  // assignment codes
  // ----------------------------------------------------------------
  localparam logic [CODE_W-1:0] CODE_UNUSED = 7'h00;
  localparam int CODE_CMD_BASE = 1;
  localparam int CODE_GP_BASE = 32;
  localparam int CODE_DSEL_BASE = 48;
  localparam int CODE_POS_LIMIT = 60;
  localparam int CODE_NEG_LIMIT = 61;
  localparam int CODE_HOME_SENSOR = 62;
  localparam int CODE_SLIT_SENSOR = 63;
  localparam int CODE_ALARM = 65;
  localparam int CODE_WARNING = 66;
  localparam int CODE_READY = 67;
  localparam int CODE_MOVING = 68;
  localparam int CODE_POS_DONE = 69;
  localparam int CODE_HOME_POS = 70;
  localparam int CODE_TORQUE_LIMIT = 71;
  localparam int CODE_TIMING = 72;
  localparam int CODE_AREA_BASE = 73;
  localparam int CODE_BUSY = 80;
  localparam int CODE_MAIN_POWER = 82;

  // command codes 1..13 and 16..18 exist; 14 and 15 do not
  localparam logic [CMD_COUNT-1:0] CMD_DEFINED_MASK = 18'h39fff;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [SLOT_COUNT-1:0] SLOT_RESET = 16'h0000;
  localparam logic [PIN_COUNT-1:0] PIN_RESET = 10'h000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pos_limit;
    logic neg_limit;
    logic home;
    logic slit;
  } ros_sensor_t;

  typedef struct packed {
    logic alarm_flag;
    logic warning_flag;
    logic ready;
    logic moving;
    logic pos_done;
    logic home_pos;
    logic torque_limit_flag;
    logic rotation_timing_pulse;
    logic [2:0] position_area_flag;
    logic internal_busy_flag;
    logic main_power_flag;
  } ros_status_t;

  typedef logic [SLOT_COUNT-1:0][CODE_W-1:0] ros_code_array_t;

endpackage : ros_pkg

// File: core/ros_slot.sv
`timescale 1ns/1ps

module ros_slot
  import ros_pkg::*;
(
  input wire logic clk, // driver clock
  input wire logic reset, // synchronous, active high
  input wire logic clk_en, // freezes state while low
  input wire logic [CODE_W-1:0] code, // assignment code of this slot
  input wire logic [SRC_W-1:0] src_vec, // every source, indexed by code
  input wire logic [SRC_W-1:0] defined_vec, // which codes exist
  output logic slot_ff, // selected bit
  output logic unused_ff, // slot carries code zero
  output logic bad_code_ff // slot carries an undefined code
);

  // ----------------------------------------------------------------
  // selection
  // ----------------------------------------------------------------
  logic code_is_unused;
  logic code_is_defined;
  logic nxt_slot;
  logic nxt_unused;
  logic nxt_bad_code;

  // code zero drives nothing onto the slot
  assign code_is_unused = (code == CODE_UNUSED); // see RULE_02
  assign code_is_defined = defined_vec[code];
  // undefined codes read 0 and touch only this slot
  assign nxt_slot = code_is_defined & src_vec[code]; // see RULE_18
  assign nxt_unused = code_is_unused;
  assign nxt_bad_code = !code_is_defined && !code_is_unused; // see RULE_18

  // ----------------------------------------------------------------
  // output register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      slot_ff <= 1'b0;
      unused_ff <= 1'b1;
      bad_code_ff <= 1'b0;
    end else if (clk_en) begin
      slot_ff <= nxt_slot;
      unused_ff <= nxt_unused;
      bad_code_ff <= nxt_bad_code;
    end
  end

endmodule : ros_slot

// File: core/ros_top.sv
`timescale 1ns/1ps

// Notes on behaviour
// RULE_01: sixteen slots, each picked by its code
// RULE_02: code zero leaves the slot unused
// RULE_03: codes 32-47 show general-purpose bits 0-15
// RULE_04: codes 48-53 mirror data-select inputs 0-5
// RULE_05: codes 60-63 mirror limit, home, slit sensors
// RULE_06: code 65 shows alarm, normally open
// RULE_07: code 66 shows warning present
// RULE_08: code 67 shows driver ready
// RULE_09: code 68 shows motor operating
// RULE_10: code 69 shows positioning completed
// RULE_11: code 70 shows motor at home
// RULE_12: code 71 shows load beyond torque range
// RULE_13: code 72 shows 7.2 degree timing pulse
// RULE_14: codes 73-75 show position areas one-three
// RULE_15: code 80 shows internal processing busy
// RULE_16: code 82 shows main power, AC only
// RULE_17: codes 1-13 and 16-18 mirror operation-command inputs
// RULE_18: undefined codes read zero, others untouched
module ros_top
  import ros_pkg::*;
#(
  parameter bit HAS_MAIN_POWER = 1'b1 // AC-powered variant carries code 82
) (
  input wire logic clk, // driver clock, 100 MHz
  input wire logic reset, // synchronous, active high
  input wire logic clk_en, // freezes all state while low
  input wire ros_code_array_t slot_code, // assignment code per slot
  input wire logic [GP_COUNT-1:0] general_purpose_bit, // general bits, same clock
  input wire logic [DSEL_COUNT-1:0] data_select_pin, // data-select input pins
  input wire ros_sensor_t sensor_pin, // limit, home and slit sensor pins
  input wire logic [CMD_COUNT-1:0] operation_command, // resolved command inputs
  input wire ros_status_t driver_status, // driver status, same clock
  output logic [SLOT_COUNT-1:0] remote_output_slot, // slot bits to the master
  output logic [SLOT_COUNT-1:0] slot_unused, // slot holds code zero
  output logic [SLOT_COUNT-1:0] slot_code_bad // slot holds an undefined code
);

  // ----------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------
  // the pins arrive from outside the clock domain; the first stage is
  // read only by the second, and a change is accepted once the second
  // and third stages agree, which filters a single-cycle glitch
  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_s1_ff;
  logic [PIN_COUNT-1:0] pin_s2_ff;
  logic [PIN_COUNT-1:0] pin_s3_ff;
  logic [PIN_COUNT-1:0] pin_clean_ff;
  logic [PIN_COUNT-1:0] nxt_pin_clean;

  assign pin_raw = {data_select_pin, sensor_pin};

  // accept a level only where the late stages agree
  assign nxt_pin_clean = (pin_s2_ff & pin_s3_ff) | (pin_clean_ff & (pin_s2_ff | pin_s3_ff));

  // three-stage capture of the pins
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_s1_ff <= PIN_RESET;
      pin_s2_ff <= PIN_RESET;
      pin_s3_ff <= PIN_RESET;
    end else if (clk_en) begin
      pin_s1_ff <= pin_raw;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  // filtered pin levels
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_clean_ff <= PIN_RESET;
    end else if (clk_en) begin
      pin_clean_ff <= nxt_pin_clean;
    end
  end

  // ----------------------------------------------------------------
  // unpacking of the filtered pins
  // ----------------------------------------------------------------
  logic [DSEL_COUNT-1:0] data_select_echo;
  ros_sensor_t sensor_echo;
  logic positive_limit_echo;
  logic negative_limit_echo;
  logic home_sensor_echo;
  logic slit_sensor_echo;

  assign data_select_echo = pin_clean_ff[PIN_COUNT-1:4];
  assign sensor_echo = pin_clean_ff[3:0];
  assign positive_limit_echo = sensor_echo.pos_limit;
  assign negative_limit_echo = sensor_echo.neg_limit;
  assign home_sensor_echo = sensor_echo.home;
  assign slit_sensor_echo = sensor_echo.slit;

  // ----------------------------------------------------------------
  // unpacking of the same-clock sources
  // ----------------------------------------------------------------
  // these arrive on the driver clock already, so they take no filter
  // and reach the slot register after one edge
  logic alarm_flag;
  logic warning_flag;
  logic driver_ready;
  logic motor_moving;
  logic position_done;
  logic at_home_position;
  logic torque_limit_flag;
  logic rotation_timing_pulse;
  logic [2:0] position_area_flag;
  logic internal_busy_flag;
  logic main_power_flag;
  logic [CMD_COUNT-1:0] command_echo;

  // status fields, one named wire each
  assign alarm_flag = driver_status.alarm_flag;
  assign warning_flag = driver_status.warning_flag;
  assign driver_ready = driver_status.ready;
  assign motor_moving = driver_status.moving;
  assign position_done = driver_status.pos_done;
  assign at_home_position = driver_status.home_pos;
  assign torque_limit_flag = driver_status.torque_limit_flag;
  assign rotation_timing_pulse = driver_status.rotation_timing_pulse;
  assign position_area_flag = driver_status.position_area_flag;
  assign internal_busy_flag = driver_status.internal_busy_flag;
  assign main_power_flag = driver_status.main_power_flag;

  // commands 14 and 15 have no source and always read zero
  assign command_echo = operation_command & CMD_DEFINED_MASK; // see RULE_17

  // ----------------------------------------------------------------
  // main power source
  // ----------------------------------------------------------------
  // only the AC-powered variant reports main power; elsewhere the
  // code stays undefined and reads zero
  logic main_power_src;

  assign main_power_src = HAS_MAIN_POWER & main_power_flag; // see RULE_16

  // ----------------------------------------------------------------
  // source vector, one bit per assignment code
  // ----------------------------------------------------------------
  logic [SRC_W-1:0] src_vec;

  always_comb begin
    src_vec = '0;
    // operation-command echoes
    src_vec[CODE_CMD_BASE +: CMD_COUNT] = command_echo; // see RULE_17
    // general-purpose bits, 0 off and 1 on
    src_vec[CODE_GP_BASE +: GP_COUNT] = general_purpose_bit; // see RULE_03
    // data-select echoes
    src_vec[CODE_DSEL_BASE +: DSEL_COUNT] = data_select_echo; // see RULE_04
    // sensor echoes in code order
    src_vec[CODE_POS_LIMIT] = positive_limit_echo; // see RULE_05
    src_vec[CODE_NEG_LIMIT] = negative_limit_echo; // see RULE_05
    src_vec[CODE_HOME_SENSOR] = home_sensor_echo; // see RULE_05
    src_vec[CODE_SLIT_SENSOR] = slit_sensor_echo; // see RULE_05
    // alarm, high while present
    src_vec[CODE_ALARM] = alarm_flag; // see RULE_06
    src_vec[CODE_WARNING] = warning_flag; // see RULE_07
    src_vec[CODE_READY] = driver_ready; // see RULE_08
    src_vec[CODE_MOVING] = motor_moving; // see RULE_09
    src_vec[CODE_POS_DONE] = position_done; // see RULE_10
    src_vec[CODE_HOME_POS] = at_home_position; // see RULE_11
    src_vec[CODE_TORQUE_LIMIT] = torque_limit_flag; // see RULE_12
    // pulse made by the driver once per 7.2 degrees of shaft rotation
    src_vec[CODE_TIMING] = rotation_timing_pulse; // see RULE_13
    src_vec[CODE_AREA_BASE +: 3] = position_area_flag; // see RULE_14
    src_vec[CODE_BUSY] = internal_busy_flag; // see RULE_15
    src_vec[CODE_MAIN_POWER] = main_power_src; // see RULE_16
  end

  // ----------------------------------------------------------------
  // set of defined codes
  // ----------------------------------------------------------------
  // built from the same positions as the sources so the two cannot drift
  logic [SRC_W-1:0] defined_vec;

  always_comb begin
    defined_vec = '0;
    defined_vec[CODE_CMD_BASE +: CMD_COUNT] = CMD_DEFINED_MASK;
    defined_vec[CODE_GP_BASE +: GP_COUNT] = '1;
    defined_vec[CODE_DSEL_BASE +: DSEL_COUNT] = '1;
    defined_vec[CODE_POS_LIMIT] = 1'b1;
    defined_vec[CODE_NEG_LIMIT] = 1'b1;
    defined_vec[CODE_HOME_SENSOR] = 1'b1;
    defined_vec[CODE_SLIT_SENSOR] = 1'b1;
    defined_vec[CODE_ALARM] = 1'b1;
    defined_vec[CODE_WARNING] = 1'b1;
    defined_vec[CODE_READY] = 1'b1;
    defined_vec[CODE_MOVING] = 1'b1;
    defined_vec[CODE_POS_DONE] = 1'b1;
    defined_vec[CODE_HOME_POS] = 1'b1;
    defined_vec[CODE_TORQUE_LIMIT] = 1'b1;
    defined_vec[CODE_TIMING] = 1'b1;
    defined_vec[CODE_AREA_BASE +: 3] = 3'h7;
    defined_vec[CODE_BUSY] = 1'b1;
    // absent on the DC variant, where code 82 counts as undefined
    defined_vec[CODE_MAIN_POWER] = HAS_MAIN_POWER; // see RULE_16
  end

  // ----------------------------------------------------------------
  // per-slot selectors
  // ----------------------------------------------------------------
  // each slot decodes only its own code, so a bad code in one slot
  // cannot disturb another
  genvar gi;
  generate
    for (gi = 0; gi < SLOT_COUNT; gi++) begin : g_slot
      ros_slot u_slot ( // see RULE_01
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .code(slot_code[gi]),
        .src_vec(src_vec),
        .defined_vec(defined_vec),
        .slot_ff(remote_output_slot[gi]),
        .unused_ff(slot_unused[gi]),
        .bad_code_ff(slot_code_bad[gi])
      );
    end
  endgenerate

endmodule : ros_top

// File: sim/ros_master_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// network master, polling the slots
// ----------------------------------------------------------------
module ros_master_model
  import ros_pkg::*;
(
  input wire logic clk, // driver clock
  input wire logic [SLOT_COUNT-1:0] slot, // slot bits from the device
  output logic [SLOT_COUNT-1:0] seen_ff // last poll result
);
  // cyclic read of every slot, one poll per edge
  always_ff @(posedge clk) begin
    seen_ff <= slot;
  end
endmodule : ros_master_model

// File: sim/ros_top_chk.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// slot zero checks, the bench rotates every table code through it
// ----------------------------------------------------------------
module ros_top_chk
  import ros_pkg::*;
#(
  parameter bit HAS_MAIN_POWER = 1'b1 // code 82 present
) (
  input wire logic clk, // driver clock
  input wire logic reset, // sync reset
  input wire logic clk_en, // state enable
  input wire ros_code_array_t slot_code, // slot codes
  input wire logic [GP_COUNT-1:0] general_purpose_bit, // general bits
  input wire logic [CMD_COUNT-1:0] operation_command, // command inputs
  input wire ros_status_t driver_status, // driver status
  input wire logic [SLOT_COUNT-1:0] remote_output_slot, // slot bits
  input wire logic [SLOT_COUNT-1:0] slot_unused, // code zero flags
  input wire logic [SLOT_COUNT-1:0] slot_code_bad // undefined code flags
);
  wire [CODE_W-1:0] c = slot_code[0];
  wire s = remote_output_slot[0];
  // an edge at which the slot registers load a new selection
  wire live = clk_en & !reset;
  logic gp_ff;
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  // general bit picked by the code, one cycle late like the slot
  always_ff @(posedge clk) begin
    gp_ff <= general_purpose_bit[c[3:0]];
  end
  property p_unused;
    live && c == 0 |=> slot_unused[0] && !s && !slot_code_bad[0];
  endproperty
  a_unused: assert property (p_unused) else $error("unused slot wrong");
  property p_gp;
    live && c inside {[32:47]} |=> s == gp_ff;
  endproperty
  a_gp: assert property (p_gp) else $error("general bit wrong");
  property p_alarm;
    live && c == 65 |=> s == $past(driver_status.alarm_flag);
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm slot wrong");
  property p_ready;
    live && c == 67 ##1 1'b1 |-> s == $past(driver_status.ready);
  endproperty
  a_ready: assert property (p_ready) else $error("ready slot wrong");
  property p_timing;
    live && c == 72 |=> $past(driver_status.rotation_timing_pulse) == s;
  endproperty
  a_timing: assert property (p_timing) else $error("timing slot wrong");
  property p_power;
    live && c == 82 |=> s == (HAS_MAIN_POWER && $past(driver_status.main_power_flag));
  endproperty
  a_power: assert property (p_power) else $error("power slot wrong");
  property p_cmd;
    live && c == 1 |=> s == $past(operation_command[0]);
  endproperty
  a_cmd: assert property (p_cmd) else $error("command echo wrong");
  property p_bad;
    live && c inside {14, 15, 64} |=> slot_code_bad[0] && !s && !slot_unused[0];
  endproperty
  a_bad: assert property (p_bad) else $error("bad code slot wrong");
  c_alarm: cover property (clk_en && c == 65 ##1 s);
  c_bad: cover property (slot_code_bad[0]);
  c_freeze: cover property (!clk_en ##1 !clk_en);
endmodule : ros_top_chk

bind ros_top ros_top_chk #(.HAS_MAIN_POWER(HAS_MAIN_POWER)) i_chk (.clk(clk), .reset(reset),
  .clk_en(clk_en), .slot_code(slot_code), .general_purpose_bit(general_purpose_bit),
  .operation_command(operation_command), .driver_status(driver_status),
  .remote_output_slot(remote_output_slot), .slot_unused(slot_unused),
  .slot_code_bad(slot_code_bad));

// File: sim/ros_top_tb.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// slot selection bench
// ----------------------------------------------------------------
module ros_top_tb
  import ros_pkg::*;
;
  localparam int NR = 26;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  ros_code_array_t code = '0;
  logic [46:0] src = '0; // status, commands, general bits
  logic [5:0] dsel = '0;
  ros_sensor_t sens = '0;
  wire [15:0] slot, unused, bad, seen;
  int fail_count = 0;
  int checked = 0;
  // code, source bit in src or -1, kind 0 plain 1 unused 2 bad
  int row [NR][3] = '{
    '{0, -1, 1},
    '{32, 0, 0}, '{47, 15, 0}, '{40, 8, 0},
    '{1, 16, 0}, '{13, 28, 0}, '{16, 31, 0}, '{18, 33, 0},
    '{14, -1, 2}, '{15, -1, 2}, '{19, -1, 2}, '{64, -1, 2}, '{127, -1, 2},
    '{65, 46, 0}, '{66, 45, 0}, '{67, 44, 0},
    '{68, 43, 0}, '{69, 42, 0}, '{70, 41, 0}, '{71, 40, 0},
    '{72, 39, 0}, '{73, 36, 0}, '{74, 37, 0}, '{75, 38, 0},
    '{80, 35, 0}, '{82, 34, 0}
  };
  // distinct patterns so a neighbouring source never matches by luck
  logic [46:0] pat [4] = '{47'h2aaa_aaaa_aaaa, 47'h3333_3333_3333, 47'h0f0f_0f0f_0f0f,
    47'h00ff_00ff_00ff};

  ros_top i_dut (.clk(clk), .reset(reset), .clk_en(clk_en), .slot_code(code),
    .general_purpose_bit(src[15:0]), .data_select_pin(dsel), .sensor_pin(sens),
    .operation_command(src[33:16]), .driver_status(src[46:34]),
    .remote_output_slot(slot), .slot_unused(unused), .slot_code_bad(bad));
  ros_master_model i_mst (.clk(clk), .slot(slot), .seen_ff(seen));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  // the tests need under 1000 cycles
  initial begin
    #50us;
    fail_count++;
    wrap_up();
  end

  // table, then pins, pulse, freeze and reset by hand
  initial begin
    logic [15:0] es, eu, eb;
    int j;
    repeat (15) @(posedge clk);
    @(negedge clk);
    check("reset slot", slot, 16'h0000);
    check("reset unused", unused, 16'hffff);
    @(posedge clk);
    reset <= 1'b0;
    for (int r = 0; r < NR; r++) begin
      for (int p = 0; p < 8; p++) begin
        @(posedge clk);
        for (int i = 0; i < 16; i++) code[i] <= 7'(row[(r + i) % NR][0]);
        src <= p[0] ? ~pat[p / 2] : pat[p / 2];
        @(posedge clk);
        @(negedge clk);
        for (int i = 0; i < 16; i++) begin
          j = (r + i) % NR;
          es[i] = row[j][1] >= 0 && src[row[j][1]];
          eu[i] = row[j][2] == 1;
          eb[i] = row[j][2] == 2;
        end
        check("slot", slot, es);
        check("unused", unused, eu);
        check("bad", bad, eb);
      end
    end
    $display("table test done");
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      for (int i = 0; i < 16; i++) code[i] <= 7'(i < 6 ? 48 + i : i < 10 ? 54 + i : 0);
      dsel <= p ? 6'h2a : 6'h15;
      sens <= p ? 4'h6 : 4'h9;
      repeat (6) @(posedge clk);
      @(negedge clk);
      es = {6'h00, sens[0], sens[1], sens[2], sens[3], dsel};
      check("pins", slot, es);
    end
    check("master", seen, es);
    // one-cycle spike on each pin that was low must not reach the slots
    @(posedge clk);
    dsel <= 6'h3f;
    sens <= 4'hf;
    @(posedge clk);
    dsel <= 6'h2a;
    sens <= 4'h6;
    repeat (7) begin
      @(negedge clk);
      check("pulse", slot, es);
    end
    @(posedge clk);
    clk_en <= 1'b0;
    code <= '0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check("freeze", slot, es);
    @(posedge clk);
    clk_en <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check("unused all", unused, 16'hffff);
    @(posedge clk);
    code <= {16{7'h41}};
    src <= '1;
    reset <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check("reset slot", slot, 16'h0000);
    check("reset bad", bad, 16'h0000);
    check("mid reset unused", unused, 16'hffff);
    @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    check("alarm all", slot, 16'hffff);
    $display("awkward tests done");
    wrap_up();
  end
endmodule : ros_top_tb
